// File: exec_pkg.sv
// Shared constants and carrier types for the call and bit-operation executor.
// Assumes a 14-bit instruction word and a 13-bit program counter.
package exec_pkg;

    localparam int PC_W        = 13;
    localparam int INSN_W      = 14;
    localparam int FADDR_W     = 7;
    localparam int DATA_W      = 8;

    // Opcode fields.
    localparam int CALL_TOP    = 13;
    localparam int CALL_BOT    = 11;
    localparam int IMM_TOP     = 10;
    localparam int BIT_TOP     = 9;
    localparam int BIT_BOT     = 7;
    localparam int OP_TOP      = 13;
    localparam int OP_BOT      = 10;
    localparam int LATCH_TOP   = 4;
    localparam int LATCH_BOT   = 3;

    localparam logic [2:0] CALL_CODE     = 3'h4;
    localparam logic [3:0] BIT_SET_CODE  = 4'h5;
    localparam logic [3:0] BIT_TEST_CODE = 4'h7;

    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam int CALL_CYCLES  = 2;

    typedef enum logic [1:0] {
        ST_RUN   = 2'h0,
        ST_FLUSH = 2'h1
    } exec_state_t;

    // Register file write request.
    typedef struct packed {
        logic               en;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0]  data;
    } reg_write_t;

    // Stack push request.
    typedef struct packed {
        logic            en;
        logic [PC_W-1:0] addr;
    } stack_push_t;

endpackage

// File: call_bit_exec.sv
// Executor for the subroutine call, bit set and bit test skip operations.
// Assumes the fetch stage presents one instruction per cycle with its PC,
// and the register file returns read data for FADDR_O in the same cycle.
`timescale 1ns/100ps
module call_bit_exec (
    input  wire logic                        MCLK_I,
    input  wire logic                        RSTN_I,
    input  wire logic                        INSN_VALID_I,
    input  wire logic [exec_pkg::INSN_W-1:0] INSN_I,
    input  wire logic [exec_pkg::PC_W-1:0]   PC_I,
    input  wire logic [7:0]                  PC_PAGE_HIGH_LATCH_I,
    input  wire logic [exec_pkg::DATA_W-1:0] RDATA_I,
    output logic [exec_pkg::FADDR_W-1:0]     FADDR_O,
    output exec_pkg::reg_write_t             REG_WRITE_O,
    output exec_pkg::stack_push_t            STACK_TOP_PUSH_O,
    output logic                             PC_LOAD_O,
    output logic [exec_pkg::PC_W-1:0]        PC_TARGET_O,
    output logic                             FLUSH_O
);

    exec_pkg::exec_state_t state_reg;
    exec_pkg::exec_state_t state_next;

    // One-hot select of a data bit for the set and test decodes.
    function automatic logic [exec_pkg::DATA_W-1:0] bit_mask(
        input logic [2:0] sel
    );
        bit_mask = 8'h01 << sel;
    endfunction

    wire logic run        = (state_reg == exec_pkg::ST_RUN) && INSN_VALID_I;
    wire logic is_call    =
        INSN_I[exec_pkg::CALL_TOP:exec_pkg::CALL_BOT] == exec_pkg::CALL_CODE;
    wire logic [3:0] op4  = INSN_I[exec_pkg::OP_TOP:exec_pkg::OP_BOT];
    wire logic is_bset    = op4 == exec_pkg::BIT_SET_CODE;
    wire logic is_btest   = op4 == exec_pkg::BIT_TEST_CODE;
    wire logic [2:0] bsel = INSN_I[exec_pkg::BIT_TOP:exec_pkg::BIT_BOT];
    wire logic [7:0] mask = bit_mask(bsel);
    wire logic do_call    = run && is_call;
    wire logic do_bset    = run && is_bset;
    wire logic do_skip    = run && is_btest && ((RDATA_I & mask) != 8'h00);

    // Call target and stack push.
    wire logic [exec_pkg::PC_W-1:0] call_target = {
        PC_PAGE_HIGH_LATCH_I[exec_pkg::LATCH_TOP:exec_pkg::LATCH_BOT],
        INSN_I[exec_pkg::IMM_TOP:0]};
    wire logic [exec_pkg::PC_W-1:0] ret_addr =
        exec_pkg::PC_W'(PC_I + 13'h0001);

    assign FADDR_O = INSN_I[exec_pkg::FADDR_W-1:0];

    wire logic [exec_pkg::DATA_W-1:0] set_data;
    for (genvar i = 0; i < exec_pkg::DATA_W; i++) begin : g_set_bit
        assign set_data[i] = RDATA_I[i] | mask[i];
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            exec_pkg::ST_RUN: begin
                if (do_call || do_skip) begin
                    state_next = exec_pkg::ST_FLUSH;
                end
            end
            exec_pkg::ST_FLUSH: begin
                state_next = exec_pkg::ST_RUN;
            end
            default: begin
                state_next = exec_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_reg <= exec_pkg::ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            STACK_TOP_PUSH_O <= '0;
        end else begin
            STACK_TOP_PUSH_O.en   <= do_call;
            STACK_TOP_PUSH_O.addr <= ret_addr;
        end
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            PC_LOAD_O   <= 1'b0;
            PC_TARGET_O <= exec_pkg::PC_RESET;
        end else begin
            PC_LOAD_O   <= do_call;
            PC_TARGET_O <= call_target;
        end
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            REG_WRITE_O <= '0;
        end else begin
            REG_WRITE_O.en   <= do_bset;
            REG_WRITE_O.addr <= INSN_I[exec_pkg::FADDR_W-1:0];
            REG_WRITE_O.data <= set_data;
        end
    end

    assign FLUSH_O = state_reg == exec_pkg::ST_FLUSH;

    property p_push;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        do_call |=> STACK_TOP_PUSH_O.en &&
            STACK_TOP_PUSH_O.addr == $past(PC_I) + 13'h0001;
    endproperty
    a_push: assert property (p_push) else $error("Return push wrong.");

    property p_low;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        do_call |=> PC_LOAD_O && PC_TARGET_O[exec_pkg::IMM_TOP:0] ==
            $past(INSN_I[exec_pkg::IMM_TOP:0]);
    endproperty
    a_low: assert property (p_low) else $error("Low target wrong.");

    property p_high;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        do_call |=> PC_TARGET_O[exec_pkg::PC_W-1:exec_pkg::IMM_TOP+1] ==
            $past(PC_PAGE_HIGH_LATCH_I[exec_pkg::LATCH_TOP:
                                       exec_pkg::LATCH_BOT]);
    endproperty
    a_high: assert property (p_high) else $error("High target wrong.");

    property p_two;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        do_call |=> FLUSH_O ##1 !FLUSH_O;
    endproperty
    a_two: assert property (p_two) else $error("Call not two cycles.");

    property p_flush_quiet;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        FLUSH_O |=> !STACK_TOP_PUSH_O.en && !REG_WRITE_O.en;
    endproperty
    a_flush_quiet: assert property (p_flush_quiet)
        else $error("Flushed slot executed.");

    property p_bset;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        do_bset |=> REG_WRITE_O.en &&
            REG_WRITE_O.data == ($past(RDATA_I) | (8'h01 << $past(bsel)));
    endproperty
    a_bset: assert property (p_bset) else $error("Bit set wrong.");

    property p_bset_one;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        REG_WRITE_O.en |-> $past(do_bset);
    endproperty
    a_bset_one: assert property (p_bset_one) else $error("Stray write.");

    property p_load_cause;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        PC_LOAD_O |-> $past(do_call) && STACK_TOP_PUSH_O.en;
    endproperty
    a_load_cause: assert property (p_load_cause)
        else $error("PC load without call.");

    property p_push_cause;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        STACK_TOP_PUSH_O.en |-> $past(do_call);
    endproperty
    a_push_cause: assert property (p_push_cause)
        else $error("Push without call.");

    // Cycles from taking a call to taking the next word.
    localparam int CALL_SPAN = exec_pkg::CALL_CYCLES;

    property p_call_span;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        do_call |-> ##CALL_SPAN (state_reg == exec_pkg::ST_RUN);
    endproperty
    a_call_span: assert property (p_call_span)
        else $error("Call span wrong.");

    property p_flush_cause;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        FLUSH_O |-> $past(do_call || do_skip);
    endproperty
    a_flush_cause: assert property (p_flush_cause)
        else $error("Flush without cause.");

    property p_bset_addr;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        do_bset |=> REG_WRITE_O.addr ==
            $past(INSN_I[exec_pkg::FADDR_W-1:0]);
    endproperty
    a_bset_addr: assert property (p_bset_addr)
        else $error("Bit set address wrong.");

    property p_bset_single;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        do_bset |=> !FLUSH_O && !STACK_TOP_PUSH_O.en && !PC_LOAD_O;
    endproperty
    a_bset_single: assert property (p_bset_single)
        else $error("Bit set not single cycle.");

endmodule

// File: subroutine_call_and_bit_ops_test.sv
// Self-checking bench for the call and bit-operation executor.
// Assumes registered outputs answer one cycle after an instruction is taken.
`timescale 1ns/100ps
module subroutine_call_and_bit_ops_test;
    logic                       clk   = 1'b0;
    logic                       rstn  = 1'b0;
    logic                       valid = 1'b0;
    logic [13:0]                insn  = 14'h0000;
    logic [12:0]                pc    = 13'h0000;
    logic [7:0]                 latch = 8'h00;
    logic [7:0]                 rdata = 8'h00;
    logic [6:0]                 faddr;
    exec_pkg::reg_write_t       wr;
    exec_pkg::stack_push_t      push;
    logic                       pc_load;
    logic [12:0]                target;
    logic                       flush;
    int                         errors  = 0;
    int                         n_tests = 0;

    call_bit_exec dut_u (.MCLK_I(clk), .RSTN_I(rstn), .INSN_VALID_I(valid),
        .INSN_I(insn), .PC_I(pc), .PC_PAGE_HIGH_LATCH_I(latch),
        .RDATA_I(rdata), .FADDR_O(faddr), .REG_WRITE_O(wr),
        .STACK_TOP_PUSH_O(push), .PC_LOAD_O(pc_load),
        .PC_TARGET_O(target), .FLUSH_O(flush));

    always #2 clk = ~clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Presents one word; the answer is visible when the task returns.
    task automatic issue(input logic [13:0] w, input logic [12:0] p,
                         input logic [7:0] l, input logic [7:0] d);
        insn  = w;
        pc    = p;
        latch = l;
        rdata = d;
        valid = 1'b1;
        @(posedge clk);
        #1;
    endtask

    task automatic quiet();
        valid = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic call_case(input logic [10:0] k, input logic [12:0] p,
                             input logic [7:0] l);
        issue({3'h4, k}, p, l, 8'h00);
        check({push.en, push.addr}, {1'b1, p + 13'h0001});
        check({pc_load, target[10:0]}, {1'b1, k});
        check(target[12:11], l[4:3]);
        check({flush, wr.en}, 2'b01 << 1);
        issue(14'h1680, p, l, 8'h00);
        check({flush, wr.en, push.en, pc_load}, 4'h0);
        quiet();
    endtask

    task automatic bit_set_case();
        for (int b = 0; b < 8; b++) begin
            issue({4'h5, b[2:0], 7'h7f - b[6:0]}, 13'h0010, 8'h00, 8'h0a);
            check({wr.en, wr.addr}, {1'b1, 7'h7f - b[6:0]});
            check(wr.data, 8'h0a | (8'h01 << b));
            check(faddr, 7'h7f - b[6:0]);
            check({flush, push.en, pc_load}, 3'h0);
        end
        quiet();
        check(wr.en, 1'b0);
    endtask

    task automatic skip_case(input logic [7:0] d, input logic exp);
        issue({4'h7, 3'h2, 7'h05}, 13'h0020, 8'h00, d);
        check({flush, wr.en, push.en}, {exp, 2'b00});
        quiet();
    endtask

    task automatic reset_case();
        repeat (6) @(posedge clk);
        #1;
        check({push.en, pc_load, flush, wr.en}, 4'h0);
        rstn = 1'b1;
    endtask

    // Reset lands in the flush slot of a call; the next call must run.
    task automatic mid_reset_case();
        issue({3'h4, 11'h155}, 13'h0456, 8'h10, 8'h00);
        check({push.en, pc_load, flush}, 3'h7);
        valid = 1'b0;
        rstn  = 1'b0;
        #1;
        check({push.en, pc_load, flush, wr.en}, 4'h0);
        check(target, exec_pkg::PC_RESET);
        @(posedge clk);
        #1;
        rstn = 1'b1;
        call_case(11'h0aa, 13'h0fff, 8'h10);
    endtask

    task automatic give_verdict();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #20000;
        errors++;
        give_verdict();
    end

    initial begin
        reset_case();
        call_case(11'h7ff, 13'h1fff, 8'h18);
        call_case(11'h000, 13'h0123, 8'he7);
        call_case(11'h2a5, 13'h0800, 8'h08);
        bit_set_case();
        skip_case(8'h04, 1'b1);
        skip_case(8'hfb, 1'b0);
        mid_reset_case();
        give_verdict();
    end
endmodule
